/* File: rtl/dlp_pkg.sv */
// Shared constants for the DRAM local path and decode block.
// Assumes a single 25 MHz pclk domain with asynchronous active-low reset.
package dlp_pkg;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DLP_CTRL_OFS = 8'h00;
  localparam logic [7:0] DLP_CMD_OFS = 8'h04;
  localparam logic [7:0] DLP_ADDR_OFS = 8'h08;
  localparam logic [7:0] DLP_WDATA_OFS = 8'h0c;
  localparam logic [7:0] DLP_STAT_OFS = 8'h10;
  localparam logic [7:0] DLP_RDATA_OFS = 8'h14;

  // CTRL fields
  localparam int DLP_CTRL_PAR_BIT = 0;
  localparam int DLP_CTRL_DLY_BIT = 1;
  localparam logic [31:0] DLP_CTRL_RST = 32'h0000_0000;

  // CMD fields: go, write, refresh, width (2 bits, 0=8..3=32)
  localparam int DLP_CMD_GO_BIT = 0;
  localparam int DLP_CMD_WR_BIT = 1;
  localparam int DLP_CMD_REF_BIT = 2;
  localparam int DLP_CMD_WID_LSB = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DLP_CLK_MHZ = 25;
  localparam int DLP_ACCESS_NS = 120;
  localparam int DLP_ACCESS_CYC =
    (DLP_ACCESS_NS * DLP_CLK_MHZ + 999) / 1000;
  localparam int DLP_DLY_TIMEOUT = 16;

  typedef enum logic [2:0] {
    DLP_IDLE = 3'b000,
    DLP_ADDR = 3'b001,
    DLP_WAIT_TAP = 3'b010,
    DLP_ACCESS = 3'b011,
    DLP_DONE = 3'b100
  } dlp_state_t;

endpackage : dlp_pkg

/* File: rtl/dlp_sync.sv */
// Two-flop synchroniser for pin inputs.
// Assumes the input is asynchronous to pclk.
module dlp_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : dlp_sync

/* File: rtl/dlp_decode.sv */
// Address gating and decodes, combinational from synchronised inputs.
// Assumes all inputs are already in the pclk domain.
module dlp_decode (
  input wire logic [31:0] cpu_addr,
  input wire logic addr_bit20_gate,
  input wire logic mem_io_n,
  input wire logic int_ack,
  input wire logic dma_io,
  output logic addr_bit20,
  output logic onboard_io_hit,
  output logic video_hit
);
  logic obio_raw;

  assign addr_bit20 = cpu_addr[20] & addr_bit20_gate;
  assign obio_raw = (cpu_addr[15:10] == 6'h00) & ~mem_io_n;
  assign onboard_io_hit = obio_raw & ~int_ack &
                          ~(dma_io & (cpu_addr == 32'h0000_0000));
  assign video_hit = (cpu_addr[31:20] == 12'h000) & cpu_addr[19];
endmodule : dlp_decode

/* File: rtl/dlp_top.sv */
// DRAM local path steering, strobes, parity enables and decodes.
// Assumes APB master on pclk; all pins asynchronous, synchronised here.
//
// Contract
// - Location input low means DRAM on memory bus; high, on local bus.
// - Drive local read direction low during DRAM reads on local bus.
// - Enable low and high local words separately on local-bus cycles.
// - Provide active-low DRAM write strobe for write cycles.
// - Drive active-high latch enable for the buffer's data latch.
// - Direction low moves memory to CPU, high moves CPU to memory.
// - With delay line enabled, launch it and time by both taps.
// - Low address lines carry DRAM address, or data on own I/O.
// - Drive the two upper DRAM address lines as outputs.
// - With parity on, enable per-lane checks by access width; the code enables them on local-bus cycles only.
// - Assert transfer-done once local memory completes a transfer.
// - Also assert transfer-done during extended refresh cycles.
// - External mapper select low leaves mapping to external mapper.
// - Gate address bit 20 low while gate input low.
// - On-board I/O decode when bits 15..10 zero and I/O cycle.
// - No on-board I/O decode on interrupt acknowledge or DMA to 0.
// - Video decode when bits 31..20 zero and bit 19 one.
module dlp_top
  import dlp_pkg::*;
#(
  parameter int ACCESS_CYC = DLP_ACCESS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dram_location_select,
  input wire logic external_mapper_sel_n,
  input wire logic delay_tap_first,
  input wire logic delay_tap_second,
  input wire logic addr_bit20_gate,
  input wire logic [31:0] cpu_addr,
  input wire logic mem_io_n,
  input wire logic int_ack,
  input wire logic dma_io,
  output logic local_mem_read_dir_n,
  output logic local_low_word_en_n,
  output logic local_high_word_en_n,
  output logic dram_write_strobe_n,
  output logic buffer_latch_open,
  output logic buffer_path_to_cpu_n,
  output logic delay_launch,
  input wire logic [7:0] muxed_addr_data_low_i,
  output logic [7:0] muxed_addr_data_low_o,
  output logic [7:0] muxed_addr_data_low_oe_n,
  output logic [1:0] dram_addr_upper,
  output logic [3:0] byte_parity_check_en_n,
  output logic local_transfer_done,
  output logic external_mapper_active,
  output logic addr_bit20,
  output logic onboard_io_decode_n,
  output logic video_window_decode
);

  // Access counter is eight bits wide
  if (ACCESS_CYC < 1 || ACCESS_CYC > 255) begin : g_bad_access
    $error("ACCESS_CYC out of range");
  end

  default clocking dlp_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pins_s;
  logic [31:0] addr_s;
  logic [7:0] mad_s;
  logic loc_s, ems_s, tap1_s, tap2_s, gate_s, mio_s, iak_s, dio_s;

  dlp_sync #(.W(8)) u_sync_pins (
    .pclk(pclk),
    .presetn(presetn),
    .din({dram_location_select, external_mapper_sel_n, delay_tap_first,
          delay_tap_second, addr_bit20_gate, mem_io_n, int_ack, dma_io}),
    .dout(pins_s)
  );
  dlp_sync #(.W(32)) u_sync_addr (
    .pclk(pclk),
    .presetn(presetn),
    .din(cpu_addr),
    .dout(addr_s)
  );
  dlp_sync #(.W(8)) u_sync_mad (
    .pclk(pclk),
    .presetn(presetn),
    .din(muxed_addr_data_low_i),
    .dout(mad_s)
  );
  assign {loc_s, ems_s, tap1_s, tap2_s, gate_s, mio_s, iak_s, dio_s} =
    pins_s;

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  logic obio_hit;
  logic vid_hit;
  logic a20_d, a20_q, obio_n_d, obio_n_q, vid_d, vid_q;

  dlp_decode u_decode (
    .cpu_addr(addr_s),
    .addr_bit20_gate(gate_s),
    .mem_io_n(mio_s),
    .int_ack(iak_s),
    .dma_io(dio_s),
    .addr_bit20(a20_d),
    .onboard_io_hit(obio_hit),
    .video_hit(vid_hit)
  );
  assign obio_n_d = ~obio_hit;
  assign vid_d = vid_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a20_q <= 1'b0;
      obio_n_q <= 1'b1;
      vid_q <= 1'b0;
    end else begin
      a20_q <= a20_d;
      obio_n_q <= obio_n_d;
      vid_q <= vid_d;
    end
  end
  assign addr_bit20 = a20_q;
  assign onboard_io_decode_n = obio_n_q;
  assign video_window_decode = vid_q;
  // Low input hands mapping to the external mapper
  assign external_mapper_active = ~ems_s;

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q, ctrl_d;
  logic [9:0] addr_q, addr_d;
  logic [7:0] wdat_q, wdat_d;
  logic [7:0] rdat_q, rdat_d;
  logic [31:0] prdata_q, prdata_d;
  logic wr_q, wr_d, ref_q, ref_d;
  logic [1:0] wid_q, wid_d;
  logic go;
  logic busy;
  logic acc;
  logic [7:0] ofs;

  assign acc = psel & penable;
  assign ofs = paddr[7:0];
  assign pready = 1'b1;
  assign pslverr = acc & (paddr[31:8] != 24'h00_0000 ||
                  !(ofs == DLP_CTRL_OFS || ofs == DLP_CMD_OFS ||
                    ofs == DLP_ADDR_OFS || ofs == DLP_WDATA_OFS ||
                    ofs == DLP_STAT_OFS || ofs == DLP_RDATA_OFS));

  always_comb begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    wr_d = wr_q;
    ref_d = ref_q;
    wid_d = wid_q;
    go = 1'b0;
    prdata_d = prdata_q;
    if (acc && pwrite && !pslverr) begin
      unique case (ofs)
        DLP_CTRL_OFS: ctrl_d = pwdata[1:0];
        DLP_ADDR_OFS: addr_d = pwdata[9:0];
        DLP_WDATA_OFS: wdat_d = pwdata[7:0];
        DLP_CMD_OFS: begin
          if (!busy && pwdata[DLP_CMD_GO_BIT]) begin
            go = 1'b1;
            wr_d = pwdata[DLP_CMD_WR_BIT];
            ref_d = pwdata[DLP_CMD_REF_BIT];
            wid_d = pwdata[DLP_CMD_WID_LSB +: 2];
          end
        end
        default: ;
      endcase
    end else if (psel && !penable && !pwrite) begin
      unique case (ofs)
        DLP_CTRL_OFS: prdata_d = {30'h0000_0000, ctrl_q};
        DLP_CMD_OFS: prdata_d = {26'h000_0000, wid_q, 1'b0, ref_q,
                                 wr_q, busy};
        DLP_ADDR_OFS: prdata_d = {22'h00_0000, addr_q};
        DLP_WDATA_OFS: prdata_d = {24'h00_0000, wdat_q};
        DLP_STAT_OFS: prdata_d = {27'h000_0000, ems_s, loc_s,
                                  local_transfer_done, busy, gate_s};
        DLP_RDATA_OFS: prdata_d = {24'h00_0000, rdat_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= DLP_CTRL_RST[1:0];
      addr_q <= '0;
      wdat_q <= '0;
      wr_q <= 1'b0;
      ref_q <= 1'b0;
      wid_q <= 2'b00;
      prdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      wr_q <= wr_d;
      ref_q <= ref_d;
      wid_q <= wid_d;
      prdata_q <= prdata_d;
    end
  end
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // DRAM cycle sequencer
  // ----------------------------------------------------------------
  dlp_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic on_local;
  logic [3:0] lanes;

  assign busy = (st_q != DLP_IDLE);
  assign on_local = loc_s;

  function automatic logic [3:0] lane_mask(input logic [1:0] w);
    // Three-bit shift so a 32-bit width does not wrap to zero lanes
    lane_mask = (4'h1 << ({1'b0, w} + 3'd1)) - 4'h1;
  endfunction : lane_mask
  assign lanes = lane_mask(wid_q);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rdat_d = rdat_q;
    unique case (st_q)
      DLP_IDLE: begin
        if (go) begin
          st_d = DLP_ADDR;
        end
      end
      DLP_ADDR: begin
        cnt_d = 8'h00;
        // Delay line times strobes for DMA and master cycles
        st_d = ctrl_q[DLP_CTRL_DLY_BIT] ? DLP_WAIT_TAP : DLP_ACCESS;
      end
      DLP_WAIT_TAP: begin
        cnt_d = cnt_q + 8'h01;
        // Timeout guards a missing delay line
        if ((tap1_s && tap2_s) || cnt_q == 8'(DLP_DLY_TIMEOUT)) begin
          st_d = DLP_ACCESS;
          cnt_d = 8'h00;
        end
      end
      DLP_ACCESS: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == 8'(ACCESS_CYC - 1)) begin
          st_d = DLP_DONE;
          if (!wr_q && !ref_q) begin
            rdat_d = mad_s;
          end
        end
      end
      DLP_DONE: st_d = DLP_IDLE;
      default: st_d = DLP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= DLP_IDLE;
      cnt_q <= 8'h00;
      rdat_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered pin outputs
  // ----------------------------------------------------------------
  logic strobe;
  logic [19:0] out_d, out_q;
  logic [7:0] mo_d, mo_q, moe_d, moe_q;

  assign strobe = (st_q == DLP_ACCESS) && !ref_q;

  always_comb begin
    // default: everything inactive outside a cycle
    out_d = {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'b00, 4'hf,
             1'b0, 6'h00};
    if (strobe) begin
      out_d[19] = !(on_local && !wr_q);
      out_d[18] = !on_local;
      // High word only for 24- and 32-bit accesses
      out_d[17] = !(on_local && lanes[2]);
      out_d[16] = !wr_q;
      out_d[15] = 1'b1;
      out_d[14] = wr_q;
      out_d[12:11] = addr_q[9:8];
      if (ctrl_q[DLP_CTRL_PAR_BIT] && on_local) begin
        out_d[10:7] = ~lanes;
      end
    end
    out_d[13] = (st_q == DLP_WAIT_TAP) && !tap2_s;
    out_d[6] = (st_q == DLP_DONE);
  end

  always_comb begin
    mo_d = 8'h00;
    moe_d = 8'hff;
    if (strobe || st_q == DLP_ADDR) begin
      mo_d = addr_q[7:0];
      moe_d = 8'h00;
    end else if (st_q == DLP_WAIT_TAP || (st_q == DLP_ACCESS && ref_q)) begin
      mo_d = addr_q[7:0];
      moe_d = 8'h00;
    end else if (st_q == DLP_DONE && wr_q) begin
      mo_d = wdat_q;
      moe_d = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'b00, 4'hf,
                1'b0, 6'h00};
      mo_q <= 8'h00;
      moe_q <= 8'hff;
    end else begin
      out_q <= out_d;
      mo_q <= mo_d;
      moe_q <= moe_d;
    end
  end

  assign local_mem_read_dir_n = out_q[19];
  assign local_low_word_en_n = out_q[18];
  assign local_high_word_en_n = out_q[17];
  assign dram_write_strobe_n = out_q[16];
  assign buffer_latch_open = out_q[15];
  assign buffer_path_to_cpu_n = out_q[14];
  assign delay_launch = out_q[13];
  assign dram_addr_upper = out_q[12:11];
  assign byte_parity_check_en_n = out_q[10:7];
  assign local_transfer_done = out_q[6];
  assign muxed_addr_data_low_o = mo_q;
  assign muxed_addr_data_low_oe_n = moe_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  idle_quiet_a: assert property ($past(st_q) == DLP_IDLE |->
    dram_write_strobe_n && !buffer_latch_open &&
    byte_parity_check_en_n == 4'hf)
    else $error("strobes active while idle");
  done_pulse_a: assert property ($rose(local_transfer_done) |=>
    !local_transfer_done)
    else $error("done not one cycle");
  cmd_done_a: assert property (go && !ctrl_q[DLP_CTRL_DLY_BIT] |->
    ##[3:260] local_transfer_done)
    else $error("transfer never completed");
  write_dir_a: assert property (!dram_write_strobe_n |->
    buffer_path_to_cpu_n)
    else $error("write strobe with path to cpu");
  read_dir_a: assert property (!local_mem_read_dir_n |->
    !buffer_path_to_cpu_n && dram_write_strobe_n)
    else $error("local read with wrong direction");
  word_en_a: assert property (!local_low_word_en_n |->
    $past(loc_s) && buffer_latch_open)
    else $error("word enable off local bus");
  hi_word_a: assert property (!local_high_word_en_n |->
    !local_low_word_en_n)
    else $error("high word enabled without low word");
  parity_a: assert property (byte_parity_check_en_n != 4'hf |->
    $past(ctrl_q[DLP_CTRL_PAR_BIT]) && !byte_parity_check_en_n[0])
    else $error("parity enable without parity");
  a20_gate_a: assert property (!$past(gate_s) |-> !addr_bit20)
    else $error("bit 20 passed while gated");
  video_a: assert property (video_window_decode |->
    $past(addr_s[19]) && !$past(addr_s[20]))
    else $error("video decode wrong");
  obio_a: assert property (!onboard_io_decode_n |->
    !$past(iak_s) && !$past(mio_s))
    else $error("on-board decode wrong");
  launch_a: assert property (delay_launch |->
    $past(ctrl_q[DLP_CTRL_DLY_BIT]))
    else $error("launch with delay line off");

  write_c: cover property (@(posedge pclk) !dram_write_strobe_n);
  read_c: cover property (@(posedge pclk) !local_mem_read_dir_n);
  refresh_c: cover property (@(posedge pclk) local_transfer_done && ref_q);
  tap_c: cover property (@(posedge pclk) delay_launch);

endmodule : dlp_top

/* File: tb/dlp_far_model.sv */
// Far-side model: delay line taps and the muxed low address/data wire.
// Assumes the design drives the mux lines only while its oe_n bits are low.
module dlp_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic delay_launch,
  input wire logic [7:0] mux_o,
  input wire logic [7:0] mux_oe_n,
  output logic delay_tap_first,
  output logic delay_tap_second,
  output logic [7:0] mux_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_q;
  logic [7:0] junk_q;
  // --------------------------------------------------------------
  // Delay line: mode 0 prompt, 1 slow, 2 dead taps
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      junk_q <= 8'h00;
    end else begin
      cnt_q <= !delay_launch ? 5'h00 :
        (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
      junk_q <= ~junk_q;
    end
  end
  assign delay_tap_first = delay_launch && mode != 2'h2 &&
    cnt_q >= (mode[0] ? 5'h06 : 5'h02);
  assign delay_tap_second = delay_launch && mode != 2'h2 &&
    cnt_q >= (mode[0] ? 5'h0b : 5'h04);
  // Undriven bits toggle so a stale value can never pass as data
  for (genvar b = 0; b < 8; b++) begin : g_wire
    assign mux_i[b] = mux_oe_n[b] ? junk_q[b] : mux_o[b];
  end
endmodule : dlp_far_model

/* File: tb/tb.sv */
// Self-checking bench for dlp_top: APB, DRAM cycles, delay line, decodes.
// Assumes dlp_far_model answers the delay taps and the mux wire.
module tb;
  import dlp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ACC = 3;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, loc = 1'b0, emap_n = 1'b1, gate = 1'b1;
  logic mem_io_n = 1'b1, int_ack = 1'b0, dma_io = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, cpu_addr = '0, prdata;
  logic [1:0] mode = 2'h0, upper, m_hi;
  logic pready, pslverr, t1, t2, rd_n, lo_n, hi_n, we_n, latch, path_n;
  logic launch, done, emap_act, a20, io_n, vid, m_mux, m_up;
  logic [7:0] mux_i, mux_o, mux_oe_n;
  logic [3:0] par_n, m_par;
  logic [4:0] m_lo;
  logic [31:0] seed = 32'h0001_3716;
  int n_mismatch = 0, checked = 0, cyc = 0, lat;

  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  dlp_top #(.ACCESS_CYC(ACC)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dram_location_select(loc), .external_mapper_sel_n(emap_n),
    .delay_tap_first(t1), .delay_tap_second(t2), .addr_bit20_gate(gate),
    .cpu_addr(cpu_addr), .mem_io_n(mem_io_n), .int_ack(int_ack),
    .dma_io(dma_io), .local_mem_read_dir_n(rd_n),
    .local_low_word_en_n(lo_n), .local_high_word_en_n(hi_n),
    .dram_write_strobe_n(we_n), .buffer_latch_open(latch),
    .buffer_path_to_cpu_n(path_n), .delay_launch(launch),
    .muxed_addr_data_low_i(mux_i), .muxed_addr_data_low_o(mux_o),
    .muxed_addr_data_low_oe_n(mux_oe_n), .dram_addr_upper(upper),
    .byte_parity_check_en_n(par_n), .local_transfer_done(done),
    .external_mapper_active(emap_act), .addr_bit20(a20),
    .onboard_io_decode_n(io_n), .video_window_decode(vid));

  dlp_far_model u_far (.pclk(pclk), .presetn(presetn), .mode(mode),
    .delay_launch(launch), .mux_o(mux_o), .mux_oe_n(mux_oe_n),
    .delay_tap_first(t1), .delay_tap_second(t2), .mux_i(mux_i));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Tracks strobes across one cycle; done edge counted from the CMD edge
  task automatic dram_op(input logic [31:0] cmd, input logic [9:0] a);
    logic [31:0] r;
    logic e;
    apb(1'b1, DLP_ADDR_OFS, {22'h0, a}, r, e);
    apb(1'b1, DLP_CMD_OFS, cmd, r, e);
    m_lo = 5'h1f;
    m_hi = 2'h0;
    m_par = 4'hf;
    m_mux = 1'b0;
    m_up = 1'b0;
    lat = 0;
    for (int n = 2; n < 60 && lat == 0; n++) begin
      @(posedge pclk);
      #1;
      m_lo &= {rd_n, lo_n, hi_n, we_n, path_n};
      m_hi |= {latch, launch};
      m_par &= par_n;
      m_mux |= (mux_oe_n === 8'h00 && mux_o === a[7:0]);
      m_up |= (latch === 1'b1 && upper === a[9:8]);
      if (done === 1'b1) begin
        lat = n;
      end
    end
    @(posedge pclk);
    #1;
    chk("idle strobes", 32'h0000_001f,
      32'({rd_n, lo_n, hi_n, we_n, path_n}));
    @(posedge pclk);
  endtask : dram_op

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [31:0] r, x, a;
    logic e, lc, wr, dm, gt, mi, ia;
    logic [1:0] w;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("reset idle", 32'h000f_8fff, 32'({rd_n, lo_n, hi_n, we_n, path_n,
      latch, launch, done, par_n, mux_oe_n}));
    @(posedge pclk);
    apb(1'b0, DLP_CTRL_OFS, 32'h0, r, e);
    chk("ctrl reset", DLP_CTRL_RST, r);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    $display("test registers done");
    apb(1'b1, DLP_CTRL_OFS, 32'h1, r, e);
    for (int i = 0; i < 16; i++) begin
      {lc, wr, w} = 4'(i);
      loc <= lc;
      repeat (4) @(posedge pclk);
      x = xs();
      dram_op({26'h0, w, 2'b00, wr, 1'b1}, x[9:0]);
      chk("done latency", 32'(2 + ACC), 32'(lat));
      chk("read dir", 32'(!(lc && !wr)), 32'(m_lo[4]));
      chk("word en", 32'({!lc, !(lc && w[1])}), 32'(m_lo[3:2]));
      chk("write strobe", 32'(!wr), 32'(m_lo[1]));
      chk("path to cpu", 32'(wr), 32'(m_lo[0]));
      if (!wr) chk("latch", 32'h1, 32'(m_hi[1]));
      chk("parity en", lc ? (32'hf << (w + 1)) & 32'hf : 32'hf,
        32'(m_par));
      chk("mux address", 32'h1, 32'(m_mux));
      chk("upper address", 32'h1, 32'(m_up));
    end
    apb(1'b1, DLP_CTRL_OFS, 32'h0, r, e);
    dram_op(32'h0000_0031, 10'h155);
    chk("parity off", 32'hf, 32'(m_par));
    dram_op(32'h0000_0005, 10'h0aa);
    chk("refresh done", 32'h1, 32'(lat != 0));
    chk("refresh quiet", 32'h1f, 32'(m_lo));
    $display("test dram cycles done");
    apb(1'b1, DLP_CTRL_OFS, 32'h2, r, e);
    for (int md = 0; md < 3; md++) begin
      mode <= 2'(md);
      dram_op(32'h0000_0031, 10'h2c3);
      chk("launch", 32'h1, 32'(m_hi[0]));
      chk("tap done", 32'h1, 32'(lat != 0 && lat < 40));
      if (md == 2) chk("tap timeout", 32'h1, 32'(lat >= 17));
    end
    mode <= 2'h0;
    $display("test delay line done");
    for (int i = 0; i < 200; i++) begin
      x = xs();
      a = xs();
      if (i % 4 == 0) a = 32'h0;
      if (i % 4 == 1) a &= 32'h0008_03ff;
      dm = (i % 4 == 0) ? 1'b1 : x[0];
      gt = dm | x[1];
      mi = (i % 4 < 2) ? 1'b0 : x[2];
      ia = (i % 4 == 2) ? x[3] : 1'b0;
      cpu_addr <= a;
      gate <= gt;
      mem_io_n <= mi;
      int_ack <= ia;
      dma_io <= dm;
      emap_n <= x[4];
      repeat (5) @(posedge pclk);
      #1;
      chk("a20", 32'(gt & a[20]), 32'(a20));
      chk("io decode", 32'(!(a[15:10] == 0 && !mi && !ia &&
        !(dm && a == 0))), 32'(io_n));
      chk("video", 32'(a[31:20] == 0 && a[19]), 32'(vid));
      chk("mapper", 32'(!x[4]), 32'(emap_act));
      @(posedge pclk);
    end
    $display("test decodes done");
    final_report();
  end
endmodule : tb
